// file: hdl/acfg_regs.sv
// Purpose: channel span, averaging and filter trim configuration registers
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   every setting is presented registered to the conversion engine
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps

// What this block does
// [R1] channel eight span code, read/write, upper nibble, resets to 3
// [R2] channel seven span code, read/write, lower nibble, resets to 3
// [R3] span code 0 is 2.5 V, 1 is 5 V, 2 to 11 is 10 V, rest reserved
// [R4] upper nibble of averaging register holds read/write padding count
// [R5] lower nibble picks ratio two to the n up to 8; above 8 means off
// [R6] averaging register sits at 0x08 and resets to zero
// [R7] trim registers hold six read/write bits, 1024 ohms per step
// [R8] trims for channels one to three at 0x09, 0x0A, 0x0B, reset zero
// [R9] span register for channels seven and eight at 0x06, resets to 0x33
// [R10] top two trim bits read zero and ignore writes
// [R11] stored settings drive the conversion logic continuously
module acfg_regs (
	// clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	// span settings
	output logic [3:0]                channel_seven_span_sel,
	output logic [3:0]                channel_eight_span_sel,
	output logic [2:0]                ch7_span_onehot,
	output logic [2:0]                ch8_span_onehot,
	output logic                      ch7_span_reserved,
	output logic                      ch8_span_reserved,
	// averaging settings
	output logic [3:0]                avg_padding_count,
	output logic [3:0]                avg_ratio_code,
	output logic                      avg_enable,
	output logic [8:0]                avg_ratio,
	// filter trim settings
	output logic [5:0]                channel_one_filter_trim,
	output logic [5:0]                channel_two_filter_trim,
	output logic [5:0]                channel_three_filter_trim,
	output logic [15:0]               ch1_series_filter_resistance,
	output logic [15:0]               ch2_series_filter_resistance,
	output logic [15:0]               ch3_series_filter_resistance,
	// change notice
	output logic                      cfg_update
);

	// trim code to ohms, one step per 1024 ohms
	function automatic logic [15:0] trim_ohms(input logic [5:0] code);
		logic [15:0] wide;
		wide = {10'h000, code};
		trim_ohms = 16'(wide << acfg_pkg::TRIM_STEP_SHIFT); // [R7]
	endfunction

	// averaging code to samples per result
	function automatic logic [8:0] ratio_of(input logic [3:0] code);
		logic ok;
		ok = (code <= acfg_pkg::RATIO_CODE_MAX);
		ratio_of = ok ? 9'(9'h001 << code) : 9'h001; // [R5]
	endfunction

	// one four-bit field of a register byte
	function automatic logic [3:0] nib_of(input logic [7:0] b, input int unsigned lsb);
		nib_of = b[lsb +: acfg_pkg::NIB_W];
	endfunction

	// stored fields
	logic [3:0]  span7_r;
	logic [3:0]  span8_r;
	logic [3:0]  pad_r;
	logic [3:0]  ratio_r;
	logic [5:0]  trim1_r;
	logic [5:0]  trim2_r;
	logic [5:0]  trim3_r;

	// bus slave state and answer
	acfg_pkg::acfg_bus_state_type state_r;
	acfg_pkg::acfg_bus_state_type state_nxt;
	logic        pready_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;

	// registered settings toward the conversion engine
	logic [2:0]  ch7_onehot_r;
	logic [2:0]  ch8_onehot_r;
	logic        ch7_rsvd_r;
	logic        ch8_rsvd_r;
	logic        avg_en_r;
	logic [8:0]  avg_ratio_r;
	logic [15:0] ohm1_r;
	logic [15:0] ohm2_r;
	logic [15:0] ohm3_r;
	logic        upd_r;

	// address decode
	wire hit_span  = (paddr == acfg_pkg::ADDR_SPAN78); // [R9]
	wire hit_avg   = (paddr == acfg_pkg::ADDR_AVG);    // [R6]
	wire hit_trim1 = (paddr == acfg_pkg::ADDR_TRIM1);  // [R8]
	wire hit_trim2 = (paddr == acfg_pkg::ADDR_TRIM2);
	wire hit_trim3 = (paddr == acfg_pkg::ADDR_TRIM3);
	wire hit_stat  = (paddr == acfg_pkg::ADDR_STATUS);
	wire hit_any   = hit_span | hit_avg | hit_trim1 | hit_trim2 | hit_trim3 | hit_stat;

	// access phase seen for the first time, and the completing edge
	wire acc_start = psel & penable & (state_r == acfg_pkg::ST_IDLE);
	wire acc_done  = psel & penable & (state_r == acfg_pkg::ST_REPLY);

	// a write lands only on the completing edge with lane 0 enabled
	wire wr_ok     = acc_done & pwrite & pstrb[0];
	wire wr_span   = wr_ok & hit_span;
	wire wr_avg    = wr_ok & hit_avg;
	wire wr_trim1  = wr_ok & hit_trim1;
	wire wr_trim2  = wr_ok & hit_trim2;
	wire wr_trim3  = wr_ok & hit_trim3;
	wire wr_cfg    = wr_span | wr_avg | wr_trim1 | wr_trim2 | wr_trim3;

	// write data fields
	wire [7:0] wbyte = pwdata[7:0];
	wire [3:0] w_lo  = nib_of(wbyte, acfg_pkg::SPAN_LO_LSB);
	wire [3:0] w_hi  = nib_of(wbyte, acfg_pkg::SPAN_HI_LSB);
	wire [5:0] w_trm = wbyte[acfg_pkg::TRIM_W-1:0]; // [R10]

	// read views of each register, narrow data in the low bits
	wire [7:0] rd_span  = {span8_r, span7_r};
	wire [7:0] rd_avg   = {pad_r, ratio_r};
	wire [7:0] rd_trim1 = {2'h0, trim1_r}; // [R10]
	wire [7:0] rd_trim2 = {2'h0, trim2_r}; // [R10]
	wire [7:0] rd_trim3 = {2'h0, trim3_r}; // [R10]
	wire [7:0] rd_stat  = {5'h00, avg_en_r, ch8_rsvd_r, ch7_rsvd_r};

	// read mux, unmapped addresses read zero
	wire [7:0] rd_byte  = hit_span  ? rd_span  :
	                      hit_avg   ? rd_avg   :
	                      hit_trim1 ? rd_trim1 :
	                      hit_trim2 ? rd_trim2 :
	                      hit_trim3 ? rd_trim3 :
	                      hit_stat  ? rd_stat  : 8'h00;

	// answer word and error for the addressed register
	wire [31:0] rd_word = {24'h000000, rd_byte};
	wire        rd_err  = ~hit_any; // unmapped address

	// next bus state; the reply lasts one cycle so an aborted access cannot hang the slave
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			acfg_pkg::ST_IDLE: begin
				if (acc_start) begin
					state_nxt = acfg_pkg::ST_REPLY;
				end
			end
			acfg_pkg::ST_REPLY: begin
				state_nxt = acfg_pkg::ST_IDLE;
			end
		endcase
	end

	// span decode for both channels
	wire d7_2p5;
	wire d7_5;
	wire d7_10;
	wire d7_rsvd;
	wire d8_2p5;
	wire d8_5;
	wire d8_10;
	wire d8_rsvd;

	// channel seven decoder
	acfg_span_decode u_dec7 (
		.code     (span7_r),
		.sel_2p5  (d7_2p5),
		.sel_5    (d7_5),
		.sel_10   (d7_10),
		.reserved (d7_rsvd)
	);

	// channel eight decoder
	acfg_span_decode u_dec8 (
		.code     (span8_r),
		.sel_2p5  (d8_2p5),
		.sel_5    (d8_5),
		.sel_10   (d8_10),
		.reserved (d8_rsvd)
	);

	// averaging is active only for codes 1 to 8
	wire avg_en_nxt = (ratio_r != acfg_pkg::RATIO_CODE_NONE) &
	                  (ratio_r <= acfg_pkg::RATIO_CODE_MAX); // [R5]

	// bus slave state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= acfg_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// answer: one wait cycle, then ready with data and error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= acc_start;
			prdata_r  <= acc_start ? rd_word : 32'h0000_0000;
			pslverr_r <= acc_start & rd_err;
		end
	end

	// span register for channels seven and eight
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			span7_r <= acfg_pkg::SPAN_RESET; // [R2] [R9]
			span8_r <= acfg_pkg::SPAN_RESET; // [R1] [R9]
		end else if (wr_span) begin
			span7_r <= w_lo; // [R2]
			span8_r <= w_hi; // [R1]
		end
	end

	// averaging register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_r   <= acfg_pkg::AVG_RESET[acfg_pkg::SPAN_HI_LSB +: acfg_pkg::NIB_W]; // [R6]
			ratio_r <= acfg_pkg::AVG_RESET[acfg_pkg::SPAN_LO_LSB +: acfg_pkg::NIB_W]; // [R6]
		end else if (wr_avg) begin
			pad_r   <= w_hi; // [R4]
			ratio_r <= w_lo; // [R5]
		end
	end

	// filter trim, channel one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim1_r <= acfg_pkg::TRIM_RESET; // [R8]
		end else if (wr_trim1) begin
			trim1_r <= w_trm; // [R7]
		end
	end

	// filter trim, channel two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim2_r <= acfg_pkg::TRIM_RESET; // [R8]
		end else if (wr_trim2) begin
			trim2_r <= w_trm; // [R7]
		end
	end

	// filter trim, channel three
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim3_r <= acfg_pkg::TRIM_RESET; // [R8]
		end else if (wr_trim3) begin
			trim3_r <= w_trm; // [R7]
		end
	end

	// decoded span selects, one cycle behind the stored code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch7_onehot_r <= 3'h4;
			ch8_onehot_r <= 3'h4;
			ch7_rsvd_r   <= 1'b0;
			ch8_rsvd_r   <= 1'b0;
		end else begin
			ch7_onehot_r <= {d7_10, d7_5, d7_2p5}; // [R3] [R11]
			ch8_onehot_r <= {d8_10, d8_5, d8_2p5}; // [R3] [R11]
			ch7_rsvd_r   <= d7_rsvd; // [R3]
			ch8_rsvd_r   <= d8_rsvd; // [R3]
		end
	end

	// decoded averaging values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			avg_en_r    <= 1'b0;
			avg_ratio_r <= 9'h001;
		end else begin
			avg_en_r    <= avg_en_nxt; // [R5] [R11]
			avg_ratio_r <= ratio_of(ratio_r); // [R5] [R11]
		end
	end

	// decoded trim resistances
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ohm1_r      <= 16'h0000;
			ohm2_r      <= 16'h0000;
			ohm3_r      <= 16'h0000;
		end else begin
			ohm1_r      <= trim_ohms(trim1_r); // [R7] [R11]
			ohm2_r      <= trim_ohms(trim2_r); // [R7] [R11]
			ohm3_r      <= trim_ohms(trim3_r); // [R7] [R11]
		end
	end

	// change notice, one cycle after any configuration write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upd_r <= 1'b0;
		end else begin
			upd_r <= wr_cfg; // [R11]
		end
	end

	// bus outputs
	assign pready  = pready_r;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;

	// stored settings, presented continuously
	assign channel_seven_span_sel    = span7_r;  // [R11]
	assign channel_eight_span_sel    = span8_r;  // [R11]
	assign avg_padding_count         = pad_r;    // [R4] [R11]
	assign avg_ratio_code            = ratio_r;  // [R11]
	assign channel_one_filter_trim   = trim1_r;  // [R11]
	assign channel_two_filter_trim   = trim2_r;  // [R11]
	assign channel_three_filter_trim = trim3_r;  // [R11]

	// decoded settings
	assign ch7_span_onehot              = ch7_onehot_r;
	assign ch8_span_onehot              = ch8_onehot_r;
	assign ch7_span_reserved            = ch7_rsvd_r;
	assign ch8_span_reserved            = ch8_rsvd_r;
	assign avg_enable                   = avg_en_r;
	assign avg_ratio                    = avg_ratio_r;
	assign ch1_series_filter_resistance = ohm1_r;
	assign ch2_series_filter_resistance = ohm2_r;
	assign ch3_series_filter_resistance = ohm3_r;
	assign cfg_update                   = upd_r;

endmodule

// file: hdl/acfg_pkg.sv
// Purpose: shared constants and types of the channel configuration bank
// Assumes: register indices are word indices, byte address is index times four
// Notes:   all offsets, field positions, stored-field reset values and codes live here
package acfg_pkg;

	// bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W  = 8;

	// register indices as printed, and their byte addresses
	localparam logic [9:0]        IDX_SPAN78  = 10'h006;
	localparam logic [9:0]        IDX_AVG     = 10'h008;
	localparam logic [9:0]        IDX_TRIM1   = 10'h009;
	localparam logic [9:0]        IDX_TRIM2   = 10'h00A;
	localparam logic [9:0]        IDX_TRIM3   = 10'h00B;
	localparam logic [9:0]        IDX_STATUS  = 10'h020;
	localparam logic [ADDR_W-1:0] ADDR_SPAN78 = {IDX_SPAN78, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_AVG    = {IDX_AVG, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_TRIM1  = {IDX_TRIM1, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_TRIM2  = {IDX_TRIM2, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_TRIM3  = {IDX_TRIM3, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};

	// field positions
	localparam int unsigned SPAN_LO_LSB = 0;
	localparam int unsigned SPAN_HI_LSB = 4;
	localparam int unsigned NIB_W       = 4;
	localparam int unsigned TRIM_W      = 6;
	localparam int unsigned OHMS_W      = 16;
	localparam int unsigned TRIM_STEP_SHIFT = 10;

	// reset values
	localparam logic [NIB_W-1:0]  SPAN_RESET = 4'h3;
	localparam logic [REG_W-1:0]  AVG_RESET  = 8'h00;
	localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h00;

	// span codes
	localparam logic [NIB_W-1:0] SPAN_CODE_2P5    = 4'h0;
	localparam logic [NIB_W-1:0] SPAN_CODE_5      = 4'h1;
	localparam logic [NIB_W-1:0] SPAN_CODE_10_MAX = 4'hB;

	// averaging ratio codes
	localparam logic [NIB_W-1:0] RATIO_CODE_NONE = 4'h0;
	localparam logic [NIB_W-1:0] RATIO_CODE_MAX  = 4'h8;
	localparam int unsigned      RATIO_W         = 9;

	// bus slave states
	typedef enum logic [0:0] {
		ST_IDLE  = 1'b0,
		ST_REPLY = 1'b1
	} acfg_bus_state_type;

endpackage

// file: hdl/acfg_span_decode.sv
// Purpose: decode one four-bit input span code into span selects
// Assumes: code comes straight from a stored register field
// Notes:   purely combinational; the caller registers the results
`timescale 1ns/10ps

module acfg_span_decode (
	// stored code
	input  wire logic [3:0] code,
	// decoded span
	output logic            sel_2p5,
	output logic            sel_5,
	output logic            sel_10,
	output logic            reserved
);

	// compare against the span code table
	wire is_2p5 = (code == acfg_pkg::SPAN_CODE_2P5);
	wire is_5   = (code == acfg_pkg::SPAN_CODE_5);
	wire in_map = (code <= acfg_pkg::SPAN_CODE_10_MAX);

	// every mapped code above the two low ones gives the widest span
	assign sel_2p5  = is_2p5;
	assign sel_5    = is_5;
	assign sel_10   = in_map & ~is_2p5 & ~is_5;
	assign reserved = ~in_map; // no span selected for reserved codes

endmodule

// file: verif/acfg_regs_chk.sv
// Purpose: bus timing and register effect checks of the configuration bank
// Assumes: one wait state per transfer, settings updated at the commit edge
// Notes:   decoded outputs trail their stored code by one cycle
`timescale 1ns/10ps

module acfg_regs_chk (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// settings
	input wire logic [3:0]  channel_seven_span_sel,
	input wire logic [3:0]  channel_eight_span_sel,
	input wire logic        ch8_span_reserved,
	input wire logic [3:0]  avg_padding_count,
	input wire logic [3:0]  avg_ratio_code,
	input wire logic [8:0]  avg_ratio,
	input wire logic [5:0]  channel_two_filter_trim,
	input wire logic [5:0]  channel_three_filter_trim,
	input wire logic [15:0] ch3_series_filter_resistance
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// a write commits on the edge where pready is sampled high
	wire commit = psel && penable && pready && pwrite && pstrb[0];

	// bus handshake
	one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no ready");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
	ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable))
		else $error("ready without access");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
	rdata_quiet_a: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
	// stored fields follow the committed write
	span_write_a: assert property (commit && paddr == acfg_pkg::ADDR_SPAN78 |=>
		{channel_eight_span_sel, channel_seven_span_sel} == $past(pwdata[7:0]))
		else $error("span not stored");
	avg_write_a: assert property (commit && paddr == acfg_pkg::ADDR_AVG |=>
		{avg_padding_count, avg_ratio_code} == $past(pwdata[7:0])) else $error("avg not stored");
	trim_write_a: assert property (commit && paddr == acfg_pkg::ADDR_TRIM2 |=>
		channel_two_filter_trim == $past(pwdata[5:0])) else $error("trim not stored");
	// decoded outputs
	ohms_scale_a: assert property (ch3_series_filter_resistance ==
		{$past(channel_three_filter_trim), 10'h000}) else $error("bad resistance");
	span_reserved_a: assert property (ch8_span_reserved ==
		($past(channel_eight_span_sel) >= 4'hC)) else $error("bad reserved flag");
	ratio_value_a: assert property (avg_ratio == (($past(avg_ratio_code) <= 4'h8) ?
		(9'h001 << $past(avg_ratio_code)) : 9'h001)) else $error("bad ratio");

	// main scenarios
	cover property (commit && paddr == acfg_pkg::ADDR_SPAN78);
	cover property (pslverr);
	cover property (avg_ratio == 9'h100);
endmodule

bind acfg_regs acfg_regs_chk i_acfg_regs_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .channel_seven_span_sel,
	.channel_eight_span_sel, .ch8_span_reserved, .avg_padding_count, .avg_ratio_code,
	.avg_ratio, .channel_two_filter_trim, .channel_three_filter_trim,
	.ch3_series_filter_resistance);

// file: verif/test_acfg_regs.sv
// Purpose: register access tests of the channel configuration bank
// Assumes: apb master leaves one idle cycle between transfers
// Notes:   expected values come from the span, ratio and trim codings
`timescale 1ns/10ps

module test_acfg_regs;
	// bus and clock
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [3:0]  pstrb = 4'hF;
	logic        pready, pslverr, rerr;
	// settings seen by the conversion engine
	logic [3:0]  channel_seven_span_sel, channel_eight_span_sel, avg_padding_count, avg_ratio_code;
	logic [2:0]  ch7_span_onehot, ch8_span_onehot;
	logic        ch7_span_reserved, ch8_span_reserved, avg_enable, cfg_update;
	logic [8:0]  avg_ratio;
	logic [5:0]  channel_one_filter_trim, channel_two_filter_trim, channel_three_filter_trim;
	logic [15:0] ch1_series_filter_resistance, ch2_series_filter_resistance;
	logic [15:0] ch3_series_filter_resistance;
	int          mismatches = 0, num_checks = 0;
	logic [11:0] ta [3] = '{acfg_pkg::ADDR_TRIM1, acfg_pkg::ADDR_TRIM2, acfg_pkg::ADDR_TRIM3};
	logic [3:0]  c;

	acfg_regs i_acfg_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pready, .prdata, .pslverr, .channel_seven_span_sel, .channel_eight_span_sel,
		.ch7_span_onehot, .ch8_span_onehot, .ch7_span_reserved, .ch8_span_reserved,
		.avg_padding_count, .avg_ratio_code, .avg_enable, .avg_ratio, .channel_one_filter_trim,
		.channel_two_filter_trim, .channel_three_filter_trim, .ch1_series_filter_resistance,
		.ch2_series_filter_resistance, .ch3_series_filter_resistance, .cfg_update);

	// 100 MHz clock
	always #5 pclk = ~pclk;

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer: setup, access, hold until pready
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [2:0] exp_oh(input logic [3:0] k);
		if (k == 4'h0) return 3'h1;
		if (k == 4'h1) return 3'h2;
		return (k <= 4'hB) ? 3'h4 : 3'h0;
	endfunction

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog
	initial begin
		#100000;
		mismatches++;
		results();
	end

	// test sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, acfg_pkg::ADDR_SPAN78, 32'h0);
		cmp(rdat, 32'h33);
		cmp(32'(ch7_span_onehot), 32'h4);
		xfer(1'b0, acfg_pkg::ADDR_AVG, 32'h0);
		cmp(rdat, 32'h0);
		for (int k = 0; k < 3; k++) begin
			xfer(1'b0, ta[k], 32'h0);
			cmp(rdat, 32'h0);
		end
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			c = i[3:0];
			xfer(1'b1, acfg_pkg::ADDR_SPAN78, {24'h0, ~c, c});
			@(negedge pclk);
			cmp(32'(cfg_update), 32'h1);
			xfer(1'b0, acfg_pkg::ADDR_SPAN78, 32'h0);
			cmp(rdat, {24'h0, ~c, c});
			cmp(32'(ch7_span_onehot), 32'(exp_oh(c)));
			cmp(32'(ch8_span_onehot), 32'(exp_oh(~c)));
			cmp(32'(ch7_span_reserved), 32'(c >= 4'hC));
			cmp(32'(ch8_span_reserved), 32'(c <= 4'h3));
			cmp(32'({channel_eight_span_sel, channel_seven_span_sel}), {24'h0, ~c, c});
			xfer(1'b1, acfg_pkg::ADDR_AVG, {24'h0, ~c, c});
			xfer(1'b0, acfg_pkg::ADDR_AVG, 32'h0);
			cmp(rdat, {24'h0, ~c, c});
			cmp(32'(avg_ratio), 32'((c <= 4'h8) ? 9'h001 << c : 9'h001));
			cmp(32'(avg_enable), 32'(c >= 4'h1 && c <= 4'h8));
			cmp(32'({avg_padding_count, avg_ratio_code}), {24'h0, ~c, c});
		end
		$display("test codes done");
		xfer(1'b0, acfg_pkg::ADDR_STATUS, 32'h0);
		cmp(rdat, 32'h1);
		cmp(32'(rerr), 32'h0);
		xfer(1'b1, acfg_pkg::ADDR_STATUS, 32'hFF);
		@(negedge pclk);
		cmp(32'(cfg_update), 32'h0);
		xfer(1'b0, acfg_pkg::ADDR_STATUS, 32'h0);
		cmp(rdat, 32'h1);
		$display("test status done");
		for (int k = 0; k < 3; k++) begin
			xfer(1'b1, ta[k], 32'hFFFF_FFFF);
			xfer(1'b0, ta[k], 32'h0);
			cmp(rdat, 32'h3F);
		end
		cmp(32'(ch2_series_filter_resistance), 32'hFC00);
		for (int k = 0; k < 3; k++)
			xfer(1'b1, ta[k], 32'(k * 21 + 1));
		for (int k = 0; k < 3; k++) begin
			xfer(1'b0, ta[k], 32'h0);
			cmp(rdat, 32'(k * 21 + 1));
		end
		cmp(32'(ch1_series_filter_resistance), 32'h0400);
		cmp(32'(channel_one_filter_trim), 32'h01);
		cmp(32'(channel_three_filter_trim), 32'h2B);
		cmp(32'(ch3_series_filter_resistance), 32'hAC00);
		$display("test trims done");
		xfer(1'b1, 12'h01C, 32'h77);
		cmp(32'(rerr), 32'h1);
		xfer(1'b0, 12'h01C, 32'h0);
		cmp({rdat[31:1], rerr}, 32'h1);
		pstrb <= 4'h0;
		xfer(1'b1, acfg_pkg::ADDR_SPAN78, 32'h0);
		pstrb <= 4'hF;
		@(negedge pclk);
		cmp(32'(cfg_update), 32'h0);
		xfer(1'b0, acfg_pkg::ADDR_SPAN78, 32'h0);
		cmp(rdat, 32'h0F);
		$display("test refused done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, acfg_pkg::ADDR_SPAN78, 32'h0);
		cmp(rdat, 32'h33);
		cmp(32'(ch8_span_onehot), 32'h4);
		xfer(1'b0, acfg_pkg::ADDR_AVG, 32'h0);
		cmp(rdat, 32'h0);
		cmp(32'(ch3_series_filter_resistance), 32'h0);
		$display("test reset again done");
		results();
	end
endmodule
